/* File: pkg/pif_pkg.sv */
`default_nettype none
package pif_pkg;
  // register byte offsets on the AXI4-Lite bus
  localparam logic [3:0] OFS_ENABLE_2 = 4'h0;
  localparam logic [3:0] OFS_FLAGS_1 = 4'h4;
  localparam logic [3:0] OFS_FLAGS_2 = 4'h8;
  localparam logic [3:0] OFS_CORE_CTRL = 4'hc;
  localparam logic [3:0] OFS_ENABLE_1 = 4'h0;
  // field positions
  localparam int BIT_OSC_FAIL = 7;
  localparam int BIT_CMP_B = 6;
  localparam int BIT_CMP_A = 5;
  localparam int BIT_NV_DONE = 4;
  localparam int BIT_PERIPH_MASTER = 6;
  localparam int BIT_GLOBAL = 7;
  // implemented bits and reset values
  localparam logic [7:0] MASK_FLAGS_2 = 8'hf0;
  localparam logic [7:0] MASK_FLAGS_1 = 8'h7f;
  localparam logic [7:0] MASK_CORE_CTRL = 8'hc0;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

/* File: rtl/pif_flag_bit.sv */
`timescale 1ns/1ps
`default_nettype none
module pif_flag_bit
  import pif_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_set,
  input wire logic i_wr,
  input wire logic i_wdata,
  output logic o_flag
);
  // a set arriving with a software clear wins
  wire next_flag = i_set | (i_wr ? i_wdata : o_flag);
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_flag <= 1'b0;
    else
      o_flag <= next_flag;
  end
endmodule
`default_nettype wire

/* File: rtl/pif_irq_ctrl.sv */
// What this block does
// RULE_01 - no request without peripheral master enable
// RULE_02 - enable bit 7 gates oscillator fail
// RULE_03 - enable bit 6 gates comparator B
// RULE_04 - enable bit 5 gates comparator A
// RULE_05 - enable bit 4 gates write done
// RULE_06 - flags set regardless of enables
// RULE_07 - software clears flags before enabling
// RULE_08 - flag bit 7 set on oscillator fail
// RULE_09 - flag bits 6,5 set on comparator change
// RULE_10 - flag bit 4 set on write done
// RULE_11 - request when flag, enable, both masters set
`timescale 1ns/1ps
`default_nettype none
module pif_irq_ctrl
  import pif_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic [3:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [3:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_OSC_FAIL,
  input wire logic I_CMP_A_OUT,
  input wire logic I_CMP_B_OUT,
  input wire logic I_NV_WRITE_DONE,
  input wire logic [6:0] I_FLAGS_1_EVENTS,
  output logic O_IRQ
);
  // ****************************************
  // write channel
  // ****************************************
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  wire aw_take = I_AWVALID & O_AWREADY;
  wire w_take = I_WVALID & O_WREADY;
  wire wr_fire = (aw_held | aw_take) & (w_held | w_take) & ~O_BVALID;
  wire [3:0] wr_addr = aw_take ? I_AWADDR : aw_addr;
  wire [7:0] wr_byte = w_take ? I_WDATA[7:0] : w_data[7:0];
  wire wr_lane = w_take ? I_WSTRB[0] : w_lane0;
  wire wr_en2 = wr_fire & wr_lane & (wr_addr == OFS_ENABLE_2);
  wire wr_fl1 = wr_fire & wr_lane & (wr_addr == OFS_FLAGS_1);
  wire wr_fl2 = wr_fire & wr_lane & (wr_addr == OFS_FLAGS_2);
  wire wr_core = wr_fire & wr_lane & (wr_addr == OFS_CORE_CTRL);
  wire wr_ok = (wr_addr == OFS_ENABLE_2) | (wr_addr == OFS_FLAGS_1) |
               (wr_addr == OFS_FLAGS_2) | (wr_addr == OFS_CORE_CTRL);

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_lane0 <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        aw_addr <= I_AWADDR;
      if (w_take)
      begin
        w_data <= I_WDATA;
        w_lane0 <= I_WSTRB[0];
      end
      aw_held <= wr_fire ? 1'b0 : (aw_held | aw_take);
      w_held <= wr_fire ? 1'b0 : (w_held | w_take);
      if (wr_fire)
      begin
        O_BVALID <= 1'b1;
        O_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (I_BREADY)
        O_BVALID <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
    end
    else
    begin
      O_AWREADY <= ~(aw_held | aw_take) & ~O_BVALID & ~wr_fire;
      O_WREADY <= ~(w_held | w_take) & ~O_BVALID & ~wr_fire;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] enable_2;
  logic [7:0] core_ctrl;
  logic cmp_a_last;
  logic cmp_b_last;
  // comparators are not compared in the first cycle after reset
  logic cmp_primed;
  wire [7:0] flags_1;
  wire [7:0] flags_2;
  wire [7:0] set_2;

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      enable_2 <= RST_REG;
      core_ctrl <= RST_REG;
      cmp_a_last <= 1'b0;
      cmp_b_last <= 1'b0;
      cmp_primed <= 1'b0;
    end
    else
    begin
      if (wr_en2)
        enable_2 <= wr_byte & MASK_FLAGS_2; // [RULE_02] [RULE_03] [RULE_04] [RULE_05]
      if (wr_core)
        core_ctrl <= wr_byte & MASK_CORE_CTRL;
      cmp_a_last <= I_CMP_A_OUT;
      cmp_b_last <= I_CMP_B_OUT;
      cmp_primed <= 1'b1; // [RULE_09]
    end
  end

  // event sources, independent of any enable
  assign set_2[BIT_OSC_FAIL] = I_OSC_FAIL; // [RULE_06] [RULE_08]
  assign set_2[BIT_CMP_B] = cmp_primed & (I_CMP_B_OUT ^ cmp_b_last); // [RULE_09]
  assign set_2[BIT_CMP_A] = cmp_primed & (I_CMP_A_OUT ^ cmp_a_last); // [RULE_09]
  assign set_2[BIT_NV_DONE] = I_NV_WRITE_DONE; // [RULE_10]
  assign set_2[3:0] = 4'h0;
  assign flags_2[3:0] = 4'h0;
  assign flags_1[7] = 1'b0;

  genvar g;
  generate
    for (g = 4; g < 8; g++)
    begin : g_fl2
      pif_flag_bit u_flag (
        .i_clk(I_CLK),
        .i_nrst(I_NRST),
        .i_set(set_2[g]),
        .i_wr(wr_fl2),
        .i_wdata(wr_byte[g]),
        .o_flag(flags_2[g])
      );
    end
    for (g = 0; g < 7; g++)
    begin : g_fl1
      pif_flag_bit u_flag (
        .i_clk(I_CLK),
        .i_nrst(I_NRST),
        .i_set(I_FLAGS_1_EVENTS[g]),
        .i_wr(wr_fl1),
        .i_wdata(wr_byte[g]),
        .o_flag(flags_1[g])
      );
    end
  endgenerate

  // ****************************************
  // interrupt request
  // ****************************************
  wire any_pending = |(flags_2 & enable_2); // [RULE_11]
  wire masters_on = core_ctrl[BIT_PERIPH_MASTER] & core_ctrl[BIT_GLOBAL]; // [RULE_01]
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      O_IRQ <= 1'b0;
    else
      O_IRQ <= any_pending & masters_on; // [RULE_01] [RULE_11]
  end

  // ****************************************
  // read channel
  // ****************************************
  wire [7:0] rd_byte =
    (I_ARADDR == OFS_ENABLE_2) ? enable_2 :
    (I_ARADDR == OFS_FLAGS_1) ? flags_1 :
    (I_ARADDR == OFS_FLAGS_2) ? flags_2 :
    (I_ARADDR == OFS_CORE_CTRL) ? core_ctrl : 8'h00;
  wire rd_ok = (I_ARADDR == OFS_ENABLE_2) | (I_ARADDR == OFS_FLAGS_1) |
               (I_ARADDR == OFS_FLAGS_2) | (I_ARADDR == OFS_CORE_CTRL);
  wire ar_take = I_ARVALID & O_ARREADY;

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0;
      O_RRESP <= RESP_OKAY;
    end
    else
    begin
      O_ARREADY <= ~O_RVALID & ~ar_take;
      if (ar_take)
      begin
        O_RVALID <= 1'b1;
        O_RDATA <= {24'h0, rd_byte};
        O_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (I_RREADY)
        O_RVALID <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_osc_event;
    I_OSC_FAIL;
  endsequence

  sequence s_osc_clash;
    I_OSC_FAIL && wr_fl2;
  endsequence

  sequence s_nv_clear;
    wr_fl2 && !wr_byte[BIT_NV_DONE] && !I_NV_WRITE_DONE;
  endsequence

  AST_NO_IRQ_WITHOUT_MASTER: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_01]
    !core_ctrl[BIT_PERIPH_MASTER] |=> !O_IRQ)
    else $error("irq raised with peripheral master enable clear");
  AST_OSC_FLAG_SET: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_08]
    s_osc_event |=> flags_2[BIT_OSC_FAIL])
    else $error("oscillator fail flag not set");
  AST_FLAG_SET_REGARDLESS: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_06]
    (I_NV_WRITE_DONE && !enable_2[BIT_NV_DONE]) |=> flags_2[BIT_NV_DONE])
    else $error("write done flag not set while disabled");
  AST_CMP_CHANGE: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_09]
    (cmp_primed && I_CMP_B_OUT != $past(I_CMP_B_OUT)) |=> flags_2[BIT_CMP_B])
    else $error("comparator b change not flagged");
  AST_FLAG_STICKY: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_10]
    (flags_2[BIT_NV_DONE] && !wr_fl2) |=> flags_2[BIT_NV_DONE])
    else $error("write done flag dropped without clear");
  AST_OSC_ENABLE: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_02]
    (flags_2 == 8'h80 && !enable_2[BIT_OSC_FAIL]) |=> !O_IRQ)
    else $error("oscillator irq while disabled");
  AST_IRQ_RAISE: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_11]
    (any_pending && masters_on) |=> O_IRQ)
    else $error("irq missing");
  AST_CMP_A_ENABLE: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_04]
    (flags_2 == 8'h20 && enable_2 == 8'h20 && masters_on) |=> O_IRQ)
    else $error("comparator a irq missing");
  AST_CMP_B_ENABLE: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_03]
    (flags_2 == 8'h40 && !enable_2[BIT_CMP_B]) |=> !O_IRQ)
    else $error("comparator b irq while disabled");
  AST_NV_ENABLE: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_05]
    (flags_2 == 8'h10 && enable_2 == 8'h10 && masters_on) |=> O_IRQ)
    else $error("write done irq missing");

  AST_CMP_A_CHANGE: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_09]
    (cmp_primed && I_CMP_A_OUT != $past(I_CMP_A_OUT)) |=> flags_2[BIT_CMP_A])
    else $error("comparator a change not flagged");
  AST_CMP_B_QUIET: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_09]
    (cmp_primed && I_CMP_B_OUT == $past(I_CMP_B_OUT) && !flags_2[BIT_CMP_B] && !wr_fl2)
    |=> !flags_2[BIT_CMP_B])
    else $error("comparator b flag set without change");
  AST_CMP_A_QUIET: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_09]
    (cmp_primed && I_CMP_A_OUT == $past(I_CMP_A_OUT) && !flags_2[BIT_CMP_A] && !wr_fl2)
    |=> !flags_2[BIT_CMP_A])
    else $error("comparator a flag set without change");
  AST_OSC_SET_WINS: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_08]
    s_osc_clash |=> flags_2[BIT_OSC_FAIL])
    else $error("oscillator fail lost to a clear");
  AST_OSC_FLAG_KEPT: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_08]
    (flags_2[BIT_OSC_FAIL] && !wr_fl2) |=> flags_2[BIT_OSC_FAIL])
    else $error("oscillator fail flag dropped without clear");
  AST_NV_FLAG_SET: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_10]
    I_NV_WRITE_DONE |=> flags_2[BIT_NV_DONE])
    else $error("write done flag not set");
  AST_NV_CLEARED: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_10]
    s_nv_clear |=> !flags_2[BIT_NV_DONE])
    else $error("write done flag not cleared");
  AST_NO_IRQ_NO_GLOBAL: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_11]
    !core_ctrl[BIT_GLOBAL] |=> !O_IRQ)
    else $error("irq raised with global enable clear");
  AST_IRQ_NEEDS_PENDING: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RULE_11]
    !any_pending |=> !O_IRQ)
    else $error("irq raised with nothing pending");
endmodule
`default_nettype wire

/* File: verif/pif_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pif_core_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_irq,
  output logic [7:0] o_entries
);
  logic last;
  // one interrupt entry for each rising request level
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      last <= 1'b0;
      o_entries <= 8'h00;
    end
    else
    begin
      last <= i_irq;
      if (i_irq && !last)
        o_entries <= o_entries + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
module tb_top;
  import pif_pkg::*;
  logic clk = 1'b0, nrst = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic osc = 1'b0, cmpa = 1'b0, cmpb = 1'b0, nvd = 1'b0;
  logic [6:0] f1ev = 7'h00;
  logic [7:0] entries;
  int miscompares = 0, compares = 0, cyc = 0;
  pif_irq_ctrl i_pif_irq_ctrl (.I_CLK(clk), .I_NRST(nrst), .I_AWADDR(awaddr),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_OSC_FAIL(osc), .I_CMP_A_OUT(cmpa), .I_CMP_B_OUT(cmpb), .I_NV_WRITE_DONE(nvd),
    .I_FLAGS_1_EVENTS(f1ev), .O_IRQ(irq));
  pif_core_model i_pif_core_model (.i_clk(clk), .i_nrst(nrst), .i_irq(irq),
    .o_entries(entries));
  always #20 clk = ~clk;
  // ********
  // bus tasks
  // ********
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wr_resp(a, d, RESP_OKAY);
  endtask
  task automatic wr_resp(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= {24'h0, d}; wvalid <= 1'b1; bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge clk);
    bready <= 1'b0;
    `CHK(bresp, r)
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rd_resp(a, e, RESP_OKAY);
  endtask
  task automatic rd_resp(input logic [3:0] a, input logic [7:0] e, input logic [1:0] r);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    rready <= 1'b0;
    `CHK(rdata, {24'h0, e})
    `CHK(rresp, r)
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk);
    #1;
    `CHK(irq, e)
  endtask
  task automatic reset_values();
    rd(OFS_ENABLE_2, RST_REG);
    rd(OFS_FLAGS_1, RST_REG);
    rd(OFS_FLAGS_2, RST_REG);
    rd(OFS_CORE_CTRL, RST_REG);
  endtask
  task automatic events_set_flags();
    @(posedge clk);
    osc <= 1'b1; cmpa <= 1'b1; cmpb <= 1'b1; nvd <= 1'b1; f1ev <= 7'h7f;
    @(posedge clk);
    osc <= 1'b0; nvd <= 1'b0; f1ev <= 7'h00;
    irq_is(1'b0);
    rd(OFS_FLAGS_2, MASK_FLAGS_2);
    rd(OFS_FLAGS_2, MASK_FLAGS_2);
    rd(OFS_FLAGS_1, MASK_FLAGS_1);
    wr(OFS_FLAGS_2, 8'h00);
    rd(OFS_FLAGS_2, 8'h00);
    @(posedge clk);
    cmpb <= 1'b0;
    rd(OFS_FLAGS_2, 8'h40);
    osc <= 1'b1;
    wr(OFS_FLAGS_2, 8'h00);
    osc <= 1'b0;
    rd(OFS_FLAGS_2, 8'h80);
    wr(OFS_FLAGS_2, 8'h00);
    wr(OFS_FLAGS_1, 8'h00);
    rd(OFS_FLAGS_1, 8'h00);
  endtask
  task automatic per_bit_gating();
    logic [7:0] m;
    wr(OFS_CORE_CTRL, MASK_CORE_CTRL);
    for (int b = BIT_NV_DONE; b <= BIT_OSC_FAIL; b++)
    begin
      m = 8'h01 << b;
      wr(OFS_ENABLE_2, 8'h00);
      wr(OFS_FLAGS_2, m);
      wr(OFS_ENABLE_2, MASK_FLAGS_2 & ~m);
      irq_is(1'b0);
      wr(OFS_ENABLE_2, m);
      irq_is(1'b1);
      wr(OFS_FLAGS_2, 8'h00);
      irq_is(1'b0);
    end
  endtask
  task automatic refused_requests();
    wr_resp(4'h1, 8'h00, RESP_SLVERR);
    rd_resp(4'h1, 8'h00, RESP_SLVERR);
    wstrb <= 4'he;
    wr(OFS_ENABLE_2, 8'h00);
    wstrb <= 4'hf;
    rd(OFS_ENABLE_2, 8'h80);
  endtask
  task automatic master_enables();
    wr(OFS_CORE_CTRL, 8'h00);
    wr(OFS_ENABLE_2, 8'hff);
    wr(OFS_FLAGS_2, 8'hff);
    irq_is(1'b0);
    wr(OFS_CORE_CTRL, 8'h80);
    irq_is(1'b0);
    wr(OFS_CORE_CTRL, 8'h40);
    irq_is(1'b0);
    wr(OFS_CORE_CTRL, MASK_CORE_CTRL);
    irq_is(1'b1);
    rd(OFS_ENABLE_2, MASK_FLAGS_2);
    rd(OFS_CORE_CTRL, MASK_CORE_CTRL);
    `CHK(entries, 8'h05)
  endtask
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    reset_values();
    events_set_flags();
    per_bit_gating();
    refused_requests();
    master_enables();
    wrap_up();
  end
endmodule
`default_nettype wire
